// file: adc_demux_defs.svh
`ifndef ADC_DEMUX_DEFS_SVH
`define ADC_DEMUX_DEFS_SVH

// --------------------------------------------------------------------------
// output coding
// --------------------------------------------------------------------------
`define CODE_FULL_SCALE 8'hff
`define CODE_ZERO_SCALE 8'h00
`define CODE_MID_LOW    8'h7f
`define CODE_MID_HIGH   8'h80

// --------------------------------------------------------------------------
// latency in sample clocks, and data reset value
// --------------------------------------------------------------------------
`define PRIMARY_LATENCY 7
`define RESET_LATENCY   6
`define DATA_RESET_VAL  8'h00

`endif

// file: adc_demux_pkg.sv
package adc_demux_pkg;
  typedef enum logic [1:0] {
    full_rate_mode,
    half_rate_mode,
    quarter_rate_mode
  } rate_mode_e;
endpackage

// file: sync_delay_line.sv
`timescale 1ns/1ps
`include "adc_demux_defs.svh"

// --------------------------------------------------------------------------
// delay line: a fixed number of sample clocks, cleared by reset
// --------------------------------------------------------------------------
module sync_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_q [DEPTH];

  // first stage takes the input
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_q[0] <= '0;
    end else begin
      stage_q[0] <= din;
    end
  end

  // remaining stages shift
  genvar i;
  generate
    for (i = 1; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          stage_q[i] <= '0;
        end else begin
          stage_q[i] <= stage_q[i-1];
        end
      end
    end
  endgenerate

  assign dout = stage_q[DEPTH-1];

endmodule

// file: adc_output_demux.sv
`timescale 1ns/1ps
`include "adc_demux_defs.svh"

module adc_output_demux
  import adc_demux_pkg::*;
#(
  parameter int DATA_WIDTH = 8,
  parameter int LATENCY    = `PRIMARY_LATENCY,
  parameter int RST_LAT    = `RESET_LATENCY
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [DATA_WIDTH-1:0] sample_code,
  input  wire logic                  sample_over,
  input  wire logic                  port_split_enable,
  input  wire logic                  rate_select,
  input  wire logic                  sync_reset_in,
  output logic      [DATA_WIDTH-1:0] primary_data,
  output logic      [DATA_WIDTH-1:0] aux_data,
  output logic                       overrange,
  output logic                       data_valid_clock,
  output logic                       sync_reset_out,
  output logic                       sync_reset_out_n
);

  // ------------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------------
  logic            split_s1_q;
  logic            split_s2_q;
  logic            rate_s1_q;
  logic            rate_s2_q;
  logic            rst_s1_q;
  logic            rst_s2_q;
  rate_mode_e      mode;

  // static pins still pass two flip-flops before use
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      split_s1_q <= 1'b0;
      split_s2_q <= 1'b0;
      rate_s1_q  <= 1'b0;
      rate_s2_q  <= 1'b0;
    end else begin
      split_s1_q <= port_split_enable;
      split_s2_q <= split_s1_q;
      rate_s1_q  <= rate_select;
      rate_s2_q  <= rate_s1_q;
    end
  end

  // split low wins over rate select
  assign mode = !split_s2_q ? full_rate_mode :
                (rate_s2_q ? quarter_rate_mode : half_rate_mode);

  // ------------------------------------------------------------------------
  // reset input latch
  // ------------------------------------------------------------------------
  // an open input is held low by the pin buffer, i.e. deasserted
  // captured on the rising sample clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= sync_reset_in;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------------------
  // sample coding and latency pipeline
  // ------------------------------------------------------------------------
  logic [DATA_WIDTH-1:0] code_clamped;
  logic                  over_clamped;
  logic [DATA_WIDTH:0]   conv_out;
  logic                  conv_rst;

  // the quantizer saturates; overrange only at the top end
  assign over_clamped = sample_over && (sample_code == `CODE_FULL_SCALE);
  assign code_clamped = sample_code;

  // conversion latency, one word per sample clock
  sync_delay_line #(
    .WIDTH (DATA_WIDTH + 1),
    .DEPTH (LATENCY)
  ) u_data_pipe (
    .clock (clock),
    .nrst  (nrst),
    .din   ({over_clamped, code_clamped}),
    .dout  (conv_out)
  );

  // reset pipeline, matched to data latency less one
  sync_delay_line #(
    .WIDTH (1),
    .DEPTH (RST_LAT)
  ) u_rst_pipe (
    .clock (clock),
    .nrst  (nrst),
    .din   (rst_s2_q),
    .dout  (conv_rst)
  );

  // ------------------------------------------------------------------------
  // divider and demultiplexer
  // ------------------------------------------------------------------------
  logic [1:0]            phase_q;
  logic [1:0]            phase_d;
  logic [DATA_WIDTH-1:0] hold_q;
  logic                  hold_over_q;
  logic                  take_hold;
  logic                  load_port;
  logic                  keep_hold;
  logic [DATA_WIDTH-1:0] prim_d;
  logic [DATA_WIDTH-1:0] aux_d;
  logic                  over_d;
  logic                  dvc_d;
  logic [DATA_WIDTH-1:0] prim_q;
  logic [DATA_WIDTH-1:0] aux_q;
  logic                  over_q;
  logic                  dvc_q;
  logic                  rst_out_q;
  logic                  rst_out_n_q;

  // divider forced to phase zero while reset is held
  assign phase_d = conv_rst ? 2'h0 : phase_q + 2'h1;

  // quarter rate: phase 0 held, phase 2 loads, odd phases dropped
  assign keep_hold = (mode == quarter_rate_mode) ? (phase_q == 2'h0)
                                                 : !phase_q[0];
  assign take_hold = (mode != full_rate_mode) && keep_hold;
  assign load_port = (mode == full_rate_mode) ? 1'b1 :
                     (mode == half_rate_mode) ? phase_q[0] :
                     (phase_q == 2'h2);

  // older sample to auxiliary, newer to primary
  assign prim_d = load_port ? conv_out[DATA_WIDTH-1:0] : prim_q;
  assign aux_d  = !load_port ? aux_q :
                  (mode == full_rate_mode) ? prim_q : hold_q;

  // full rate flags primary only; split modes OR both ports
  assign over_d = !load_port ? over_q :
                  (mode == full_rate_mode) ? conv_out[DATA_WIDTH] :
                  (conv_out[DATA_WIDTH] | hold_over_q);

  // data-valid clock rises with each port update in split modes; toggles every sample clock at full rate
  assign dvc_d = (mode == full_rate_mode) ? !dvc_q :
                 (mode == half_rate_mode) ? phase_q[0] :
                 phase_q[1];

  // divider counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // older sample of the pair waits here
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hold_q      <= `DATA_RESET_VAL;
      hold_over_q <= 1'b0;
    end else if (take_hold) begin
      hold_q      <= conv_out[DATA_WIDTH-1:0];
      hold_over_q <= conv_out[DATA_WIDTH];
    end
  end

  // output ports, updated together
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prim_q <= `DATA_RESET_VAL;
      aux_q  <= `DATA_RESET_VAL;
      over_q <= 1'b0;
      dvc_q  <= 1'b0;
    end else begin
      prim_q <= prim_d;
      aux_q  <= aux_d;
      over_q <= over_d;
      dvc_q  <= dvc_d;
    end
  end

  // reset output stage at the end of the path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_out_q   <= 1'b0;
      rst_out_n_q <= 1'b1;
    end else begin
      rst_out_q   <= conv_rst;
      rst_out_n_q <= !conv_rst; // complementary leg, own flop
    end
  end

  // ------------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------------
  assign primary_data     = prim_q;
  assign aux_data         = aux_q;
  assign overrange        = over_q;
  assign data_valid_clock = dvc_q;
  assign sync_reset_out   = rst_out_q;
  assign sync_reset_out_n = rst_out_n_q; // complementary leg of the pair

endmodule

// file: adc_output_demux_assertions.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// port checker for the output demultiplexer
// ---------------------------------------------------------------
module demux_checker (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       port_split_enable,
  input wire logic       rate_select,
  input wire logic       sync_reset_in,
  input wire logic [7:0] primary_data,
  input wire logic [7:0] aux_data,
  input wire logic       overrange,
  input wire logic       data_valid_clock,
  input wire logic       sync_reset_out,
  input wire logic       sync_reset_out_n
);
  logic [1:0] cfg_q;
  logic [4:0] age_q;
  wire        ok   = (age_q == 5'h1f);
  wire        full = ok && !port_split_enable;
  wire        half = ok && port_split_enable && !rate_select;
  wire        quar = ok && port_split_enable && rate_select;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // cycles since mode pins last moved or sync reset was last high; gates mode checks
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= 2'h0;
      age_q <= 5'h00;
    end else begin
      cfg_q <= {port_split_enable, rate_select};
      if (sync_reset_in || cfg_q != {port_split_enable, rate_select}) begin
        age_q <= 5'h00;
      end else if (!ok) begin
        age_q <= age_q + 5'h01;
      end
    end
  end

  property p_upd; (half || quar) && $changed(primary_data)
    |-> $rose(data_valid_clock); endproperty
  a_upd: assert property (p_upd) else $error("port moved off dvc");
  property p_half; half && $rose(data_valid_clock)
    |=> $fell(data_valid_clock) ##1 $rose(data_valid_clock); endproperty
  a_half: assert property (p_half) else $error("half dvc period");
  property p_quar; quar && $rose(data_valid_clock)
    |=> $stable(primary_data)[*3]; endproperty
  a_quar: assert property (p_quar) else $error("quarter hold");
  property p_faux; full |-> aux_data == $past(primary_data); endproperty
  a_faux: assert property (p_faux) else $error("full aux delay");
  property p_for; full && overrange |-> primary_data == 8'hff; endproperty
  a_for: assert property (p_for) else $error("full overrange");
  property p_sor; (half || quar) && overrange
    |-> primary_data == 8'hff || aux_data == 8'hff; endproperty
  a_sor: assert property (p_sor) else $error("split overrange");
  property p_zor; full && primary_data == 8'h00 |-> !overrange; endproperty
  a_zor: assert property (p_zor) else $error("zero overrange");
  property p_rlat; $rose(sync_reset_in) |-> ##[9:10] sync_reset_out;
  endproperty
  a_rlat: assert property (p_rlat) else $error("reset latency");
  property p_rinv; sync_reset_out_n != sync_reset_out; endproperty
  a_rinv: assert property (p_rinv) else $error("reset pair");

  c_rst: cover property ($rose(sync_reset_out));
  c_quar: cover property (quar && $rose(data_valid_clock));
  c_or: cover property (overrange);
endmodule

bind adc_output_demux demux_checker u_chk (
  .clock(clock), .nrst(nrst), .port_split_enable(port_split_enable),
  .rate_select(rate_select), .sync_reset_in(sync_reset_in),
  .primary_data(primary_data), .aux_data(aux_data), .overrange(overrange),
  .data_valid_clock(data_valid_clock), .sync_reset_out(sync_reset_out),
  .sync_reset_out_n(sync_reset_out_n));

// file: capture_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// downstream capture logic in the sample clock domain
// ---------------------------------------------------------------
module capture_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       data_valid_clock,
  input  wire logic [7:0] primary_data,
  input  wire logic [7:0] aux_data,
  input  wire logic       overrange,
  output logic      [7:0] cap_primary,
  output logic      [7:0] cap_aux,
  output logic            cap_over,
  output logic            cap_seen
);
  logic dvc_q;

  // latch both ports and the flag on each rising data-valid clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dvc_q       <= 1'b0;
      cap_seen    <= 1'b0;
      cap_primary <= 8'h00;
      cap_aux     <= 8'h00;
      cap_over    <= 1'b0;
    end else begin
      dvc_q    <= data_valid_clock;
      cap_seen <= data_valid_clock && !dvc_q;
      if (data_valid_clock && !dvc_q) begin
        cap_primary <= primary_data;
        cap_aux     <= aux_data;
        cap_over    <= overrange;
      end
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// mode sweep with ramp data and sync reset per mode
// ---------------------------------------------------------------
module testbench;
  logic       clock, nrst, sample_over, port_split_enable, rate_select;
  logic       sync_reset_in, overrange, data_valid_clock, sync_reset_out;
  logic       sync_reset_out_n, cap_over, cap_seen;
  logic [7:0] sample_code, primary_data, aux_data, cap_primary, cap_aux;
  int         n_fail, n_compared;

  adc_output_demux u_dut (.clock(clock), .nrst(nrst),
    .sample_code(sample_code), .sample_over(sample_over),
    .port_split_enable(port_split_enable), .rate_select(rate_select),
    .sync_reset_in(sync_reset_in), .primary_data(primary_data),
    .aux_data(aux_data), .overrange(overrange),
    .data_valid_clock(data_valid_clock), .sync_reset_out(sync_reset_out),
    .sync_reset_out_n(sync_reset_out_n));
  capture_model u_cap (.clock(clock), .nrst(nrst),
    .data_valid_clock(data_valid_clock), .primary_data(primary_data),
    .aux_data(aux_data), .overrange(overrange), .cap_primary(cap_primary),
    .cap_aux(cap_aux), .cap_over(cap_over), .cap_seen(cap_seen));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ramp of codes; saturation flag rides with full scale
  always @(posedge clock) begin
    sample_code <= sample_code + 8'h01;
    sample_over <= (sample_code == 8'hfe);
  end

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task complete_run;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // set mode, resync, then check captured pairs against the ramp
  task run_mode(input logic split, input logic rate, input logic [7:0] step);
    int         i;
    int         n;
    logic [7:0] last;
    @(posedge clock);
    port_split_enable <= split;
    rate_select       <= rate;
    sync_reset_in     <= 1'b1;
    n = 0;
    while (sync_reset_out !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
      if (n == 4) sync_reset_in <= 1'b0;
      #1;
    end
    chk("reset_latency", 8'h09, n[7:0]);
    chk("reset_out_n", 8'h00, 8'(sync_reset_out_n));
    repeat (30) @(posedge clock);
    n = 0;
    for (i = 0; i < 600; i++) begin
      @(posedge clock);
      #1;
      if (cap_seen === 1'b1) begin
        if (n > 0) chk("pair_step", last + step, cap_aux);
        chk("port_order", cap_aux + step, cap_primary);
        chk("overrange", 8'((cap_primary == 8'hff) ||
          (split && cap_aux == 8'hff)), 8'(cap_over));
        last = cap_primary;
        n++;
      end
    end
    chk("captures", 8'h01, 8'(n >= 100));
  endtask

  initial begin
    nrst = 1'b0;
    sample_code = 8'h00;
    sample_over = 1'b0;
    port_split_enable = 1'b0;
    rate_select = 1'b0;
    sync_reset_in = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    run_mode(1'b0, 1'b1, 8'h01);
    run_mode(1'b1, 1'b0, 8'h01);
    run_mode(1'b1, 1'b1, 8'h02);
    complete_run;
  end
endmodule
